// [rtl/wwdt_top.sv]
// Windowed watchdog timer counting low-speed oscillator periods.
`timescale 1ns/1ps
module wwdt_top
   import wwdt_pkg::*;
(
   // System clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Low-speed oscillator clock, sampled as an ordinary input.
   input  wire logic        lsclk,
   // Option byte, captured once after reset release.
   input  wire logic [7:0]  opt_byte,
   // High while the device is in HALT, STOP or SNOOZE.
   input  wire logic        standby,
   // CPU access to the service register.
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_bitop,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   output wire logic [7:0]  bus_rdata,
   // Results of the watchdog.
   output wire logic        int_rst,
   output wire logic        interval_irq,
   output wire logic [7:0]  reset_cause_reg
);

   // All state of the block in one record.
   typedef struct packed {
      logic        opt_valid;   // Option byte has been captured.
      logic [7:0]  opt;         // Captured option byte.
      logic [16:0] cnt;         // Watchdog count.
      logic        ls_q;        // Previous low-speed clock level.
      logic        clr_pend;    // Key accepted, clear awaits next edge.
      logic        first_done;  // First service write has been made.
      logic        stby_q;      // Previous standby level.
      logic        fault;       // Internal reset request, held.
      logic [7:0]  rdata;       // Read data.
      logic        irq;         // Interval interrupt pulse.
      logic        cause;       // Watchdog reset cause flag.
   } wwdt_state_s;

   wwdt_state_s st;       // Registered state.
   wwdt_state_s next_st;  // Next state.

   // All helpers below are pure functions of the state and the inputs.
   // Decoded helpers.
   logic        ls_rise;   // Rising edge of the low-speed clock.
   logic        ls_fall;   // Falling edge, used for the half-period.
   logic        hit;       // Access addresses the service register.
   logic        wr_hit;    // Write to the service register.
   logic        key_ok;    // Plain byte write carrying the key.
   logic        win_shut;  // Window currently closed.
   logic        run;       // Counter may advance this edge.
   logic [16:0] ovf;       // Selected overflow count.
   logic [16:0] shut_lim;  // Count below which the window is closed.
   logic [16:0] irq_pt;    // Count at which the interrupt fires.
   logic [16:0] cnt_inc;   // Count plus one.

   // The slow clock is sampled as data, so each of its levels must last
   // longer than one system cycle; a faster oscillator would lose edges.
   // The trade is one flip-flop here instead of a second clock domain.
   // Combinational decode of the current state and inputs.
   always_comb
   begin
      ls_rise  = lsclk && !st.ls_q;
      ls_fall  = !lsclk && st.ls_q;
      hit      = (bus_addr == WWDT_KEY_ADDR);
      wr_hit   = hit && bus_wr && st.opt_valid;
      key_ok   = wr_hit && !bus_bitop && (bus_wdata == WWDT_KEY_VALUE);
      ovf      = wwdt_ovf_count(st.opt[WWDT_OPT_OVF_HI:WWDT_OPT_OVF_LO]);
      irq_pt   = (ovf >> 1) + (ovf >> 2);
      cnt_inc  = st.cnt + 17'h00001;
      // Boundary between closed and open part of the period.
      shut_lim = 17'h00000;
      if (st.opt[WWDT_OPT_STBY])
      begin
         // Code 00 is prohibited; it is treated as fully open.
         if (st.opt[WWDT_OPT_WIN_HI:WWDT_OPT_WIN_LO] == WWDT_WIN_50)
         begin
            shut_lim = ovf >> 1;
         end
         else if (st.opt[WWDT_OPT_WIN_HI:WWDT_OPT_WIN_LO] == WWDT_WIN_75)
         begin
            shut_lim = ovf >> 2;
         end
      end
      win_shut = st.first_done && (st.cnt < shut_lim);
      // Counting needs the enable option and, in standby, the run option.
      run = st.opt_valid && st.opt[WWDT_OPT_EN] && !st.fault
            && (!standby || st.opt[WWDT_OPT_STBY]);
   end

   // Priority within one cycle: a write fault or an overflow sets the
   // held reset request, a pending clear beats an overflow on the same
   // slow edge, and a standby exit clear overrides any count update.
   // Nothing here ever clears the fault; only the system reset does.
   // Next-state logic.
   always_comb
   begin
      next_st        = st;
      next_st.ls_q   = lsclk;
      next_st.stby_q = standby;
      next_st.irq    = 1'b0;
      next_st.rdata  = WWDT_READ_NONE;

      // Capture the option byte on the first cycle after release, since
      // an asynchronous reset may only load constants.
      if (!st.opt_valid)
      begin
         next_st.opt_valid = 1'b1;
         next_st.opt       = opt_byte;
      end

      // Reads never return the written key.
      if (hit && bus_rd)
      begin
         next_st.rdata = st.opt[WWDT_OPT_EN] ? WWDT_READ_ON
                                             : WWDT_READ_OFF;
      end

      // Service register writes.
      if (wr_hit)
      begin
         next_st.first_done = 1'b1;
         if (bus_bitop)
         begin
            next_st.fault = 1'b1;
         end
         else if (bus_wdata != WWDT_KEY_VALUE)
         begin
            next_st.fault = 1'b1;
         end
         else if (win_shut)
         begin
            next_st.fault = 1'b1;
         end
         else
         begin
            // Clear lands on the next low-speed edge, so it lags the
            // write by at most one period.
            next_st.clr_pend = 1'b1;
         end
      end

      // Counter advance on low-speed rising edges.
      if (ls_rise && run)
      begin
         if (st.clr_pend)
         begin
            // A pending clear beats an overflow on the same edge.
            next_st.cnt      = WWDT_CNT_RST;
            next_st.clr_pend = key_ok && !win_shut;
         end
         else if (cnt_inc == ovf)
         begin
            next_st.fault = 1'b1;
            next_st.cnt   = cnt_inc;
         end
         else
         begin
            next_st.cnt = cnt_inc;
         end
      end

      // Leaving standby with the run option clear restarts from zero.
      if (st.stby_q && !standby && !st.opt[WWDT_OPT_STBY])
      begin
         next_st.cnt      = WWDT_CNT_RST;
         next_st.clr_pend = 1'b0;
      end

      // Interval interrupt half a period after the 75% point; the count
      // is left alone so an unserviced dog still bites.
      if (ls_fall && run && st.opt[WWDT_OPT_IRQ] && (st.cnt == irq_pt))
      begin
         next_st.irq = 1'b1;
      end

      // Every watchdog reset marks its cause.
      if (next_st.fault)
      begin
         next_st.cause = 1'b1;
      end
   end

   // The asynchronous reset loads constants only; the option byte is
   // therefore captured by the next-state logic one cycle later.
   // State register.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // The cause byte has a single live bit; the others read as zero.
   // Outputs straight from the state register.
   assign bus_rdata       = st.rdata;
   assign int_rst         = st.fault;
   assign interval_irq    = st.irq;
   assign reset_cause_reg = {3'h0, st.cause, 4'h0};

   // Checks on the watchdog behaviour.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // The checks below watch the registered state and outputs. Those that
   // expect no reset exclude a same-edge overflow, and those that expect a
   // count step or a frozen count exclude a standby exit clear, since either
   // may legally change the result in that cycle.
   // None of them looks at the bench drive alone.

   AST_WRONG_KEY: assert property (
      wr_hit && !bus_bitop && bus_wdata != WWDT_KEY_VALUE |=> int_rst)
      else $error("Wrong key did not force reset.");

   AST_BIT_ACCESS: assert property (
      wr_hit && bus_bitop |=> int_rst && reset_cause_reg[WWDT_CAUSE_BIT])
      else $error("Single-bit access did not force reset.");

   AST_READ_VALUE: assert property (
      hit && bus_rd |=> bus_rdata != WWDT_KEY_VALUE
      && bus_rdata == (st.opt[WWDT_OPT_EN] ? WWDT_READ_ON : WWDT_READ_OFF))
      else $error("Service register read value wrong.");

   AST_DISABLED: assert property (
      st.opt_valid && !st.opt[WWDT_OPT_EN] |-> st.cnt == WWDT_CNT_RST)
      else $error("Disabled counter moved.");

   AST_OVERFLOW: assert property (
      ls_rise && run && !st.clr_pend && cnt_inc == ovf |=> int_rst)
      else $error("Overflow did not force reset.");

   AST_CLEAR: assert property (
      key_ok && !win_shut && !st.fault |=> st.clr_pend)
      else $error("Valid key not accepted.");

   AST_LATE_KEY: assert property (
      ls_rise && run && st.clr_pend && !st.fault && !wr_hit
      |=> st.cnt == WWDT_CNT_RST && !int_rst)
      else $error("Pending clear lost to overflow.");

   AST_CLOSED: assert property (
      key_ok && win_shut |=> int_rst)
      else $error("Closed window write did not reset.");

   AST_IRQ_POINT: assert property (
      interval_irq |-> st.opt[WWDT_OPT_IRQ] && st.cnt == irq_pt
      && !int_rst)
      else $error("Interval interrupt at wrong count.");

   AST_CAUSE: assert property (
      $rose(int_rst) |-> reset_cause_reg[WWDT_CAUSE_BIT])
      else $error("Cause flag not set with reset.");

   AST_STBY_HOLD: assert property (
      standby && st.stby_q && !st.opt[WWDT_OPT_STBY] && st.opt_valid
      |=> $stable(st.cnt) || !standby)
      else $error("Counter moved in standby.");

   AST_STBY_EXIT: assert property (
      st.stby_q && !standby && !st.opt[WWDT_OPT_STBY]
      |=> st.cnt == WWDT_CNT_RST)
      else $error("Counter not cleared on standby exit.");

   // A pending clear is used up by the first slow edge that counts.
   AST_CLEAR_LAG: assert property (
      ls_rise && run && st.clr_pend && !key_ok |=> !st.clr_pend)
      else $error("Pending clear outlived a slow edge.");

   // The first write after release never meets a closed window.
   AST_FIRST_FREE: assert property (
      key_ok && !st.first_done |-> !win_shut)
      else $error("First key write saw a closed window.");

   // A key in the open window raises no reset by itself.
   AST_OPEN_KEY: assert property (
      key_ok && !win_shut && !st.fault
      && !(ls_rise && run && !st.clr_pend && cnt_inc == ovf) |=> !int_rst)
      else $error("Open window key forced reset.");

   // Half open: closed for the first half of the overflow count.
   AST_HALF_SHUT: assert property (
      st.first_done && st.opt[WWDT_OPT_STBY]
      && st.opt[WWDT_OPT_WIN_HI:WWDT_OPT_WIN_LO] == WWDT_WIN_50
      |-> win_shut == (st.cnt < (ovf >> 1)))
      else $error("Half window boundary wrong.");

   // Three quarters open: closed for the first quarter only.
   AST_QUARTER_SHUT: assert property (
      st.first_done && st.opt[WWDT_OPT_STBY]
      && st.opt[WWDT_OPT_WIN_HI:WWDT_OPT_WIN_LO] == WWDT_WIN_75
      |-> win_shut == (st.cnt < (ovf >> 2)))
      else $error("Quarter window boundary wrong.");

   // With the standby run option clear the window never closes.
   AST_FULL_OPEN: assert property (
      !st.opt[WWDT_OPT_STBY] |-> !win_shut)
      else $error("Window closed with standby option clear.");

   // Each counted slow edge without a pending clear adds exactly one.
   AST_COUNT_STEP: assert property (
      ls_rise && run && !st.clr_pend && cnt_inc != ovf
      && !(st.stby_q && !standby) |=> st.cnt == $past(st.cnt) + 17'h00001)
      else $error("Counter did not step by one.");

   // No interval pulse unless the option asks for it.
   AST_NO_IRQ: assert property (
      !st.opt[WWDT_OPT_IRQ] |-> !interval_irq)
      else $error("Interval pulse with option clear.");

   // The interval pulse lasts a single cycle.
   AST_IRQ_ONCE: assert property (
      interval_irq |=> !interval_irq)
      else $error("Interval pulse too long.");

   // Reset request and cause flag stay up until the system reset.
   AST_FAULT_HOLD: assert property (
      int_rst |=> int_rst && reset_cause_reg[WWDT_CAUSE_BIT])
      else $error("Reset request or cause flag dropped.");

   // Once the dog has bitten, the count moves only on a standby exit clear.
   AST_FROZEN: assert property (
      int_rst && !(st.stby_q && !standby) |=> $stable(st.cnt))
      else $error("Counter moved after reset request.");

   // Read data is zero outside the cycle after a service read.
   AST_RDATA_IDLE: assert property (
      !(hit && bus_rd) |=> bus_rdata == WWDT_READ_NONE)
      else $error("Read data not idle.");

   COV_SERVICE: cover property (key_ok && st.first_done && !win_shut);
   COV_IRQ: cover property (interval_irq);
   COV_OVERFLOW: cover property (ls_rise && run && cnt_inc == ovf);
   COV_CLOSED: cover property (key_ok && win_shut);
   COV_STBY_EXIT: cover property (st.stby_q && !standby
                                  && !st.opt[WWDT_OPT_STBY]);

endmodule

// [rtl/wwdt_pkg.sv]
// Constants and helpers shared by the windowed watchdog timer.
package wwdt_pkg;

   // Service register location and data values.
   localparam logic [19:0] WWDT_KEY_ADDR   = 20'hfffab;
   localparam logic [7:0]  WWDT_KEY_VALUE  = 8'hac;
   localparam logic [7:0]  WWDT_READ_ON    = 8'h9a;
   localparam logic [7:0]  WWDT_READ_OFF   = 8'h1a;
   localparam logic [7:0]  WWDT_READ_NONE  = 8'h00;

   // Option byte field positions.
   localparam int WWDT_OPT_IRQ     = 7;
   localparam int WWDT_OPT_WIN_HI  = 6;
   localparam int WWDT_OPT_WIN_LO  = 5;
   localparam int WWDT_OPT_EN      = 4;
   localparam int WWDT_OPT_OVF_HI  = 3;
   localparam int WWDT_OPT_OVF_LO  = 1;
   localparam int WWDT_OPT_STBY    = 0;

   // Reset cause register layout.
   localparam int WWDT_CAUSE_BIT   = 4;

   // Counter width and reset values.
   localparam int              WWDT_CNT_W     = 17;
   localparam logic [16:0]     WWDT_CNT_RST   = 17'h00000;
   localparam logic [7:0]      WWDT_BYTE_RST  = 8'h00;

   // Window field codes.
   localparam logic [1:0] WWDT_WIN_50  = 2'h1;
   localparam logic [1:0] WWDT_WIN_75  = 2'h2;

   // Overflow count for each code of the overflow field, in periods.
   function automatic logic [16:0] wwdt_ovf_count(input logic [2:0] code);
      logic [16:0] val;
      val = 17'h00040;
      unique case (code)
         3'h0: val = 17'h00040;
         3'h1: val = 17'h00080;
         3'h2: val = 17'h00100;
         3'h3: val = 17'h00200;
         3'h4: val = 17'h00800;
         3'h5: val = 17'h02000;
         3'h6: val = 17'h04000;
         3'h7: val = 17'h10000;
      endcase
      return val;
   endfunction

endpackage

// [testbench/test_windowed_watchdog_timer.sv]
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
module test_windowed_watchdog_timer
   import wwdt_pkg::*;
;
   // Bench-driven inputs, all defined at time zero.
   logic        clk       = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        lsclk     = 1'b0;
   logic [7:0]  opt_byte  = 8'h00;
   logic        standby   = 1'b0;
   logic [19:0] bus_addr  = 20'h00000;
   logic        bus_wr    = 1'b0;
   logic        bus_bitop = 1'b0;
   logic        bus_rd    = 1'b0;
   logic [7:0]  bus_wdata = 8'h00;
   // Design outputs.
   logic [7:0]  bus_rdata;
   logic        int_rst;
   logic        interval_irq;
   logic [7:0]  reset_cause_reg;
   // Divider for the slow clock and bench bookkeeping.
   logic [1:0]  div = 2'h0;
   int          irq_cnt = 0;
   int          err_total = 0;
   int          comparisons = 0;
   // Window cases: option byte, slow edges before second key, reset.
   logic [7:0]  w_opt [6] = '{8'h31, 8'h31, 8'h51, 8'h51, 8'h30, 8'h71};
   int          w_gap [6] = '{10, 40, 8, 24, 10, 4};
   logic        w_exp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   // System clock at 100 MHz.
   always #5 clk = ~clk;

   wwdt_top dut (.clk(clk), .sys_rst(sys_rst), .lsclk(lsclk),
      .opt_byte(opt_byte), .standby(standby), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_bitop(bus_bitop), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .int_rst(int_rst),
      .interval_irq(interval_irq), .reset_cause_reg(reset_cause_reg));

   // Slow clock of eight system cycles, restarted by reset so that its
   // rising edges can be counted from the release.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         div <= 2'h0;
         lsclk <= 1'b0;
         irq_cnt <= 0;
      end
      else
      begin
         div <= div + 2'h1;
         if (div == 2'h3)
            lsclk <= ~lsclk;
         if (interval_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
      end
   end

   // Compares one byte result and counts it.
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up;
      $display("Counts: %0d mismatches, %0d comparisons", err_total,
               comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Resets with a new option byte; the first request waits two edges.
   task automatic start(input logic [7:0] opt);
      @(posedge clk);
      opt_byte <= opt;
      standby <= 1'b0;
      sys_rst <= 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Waits for slow clock rises, or for system cycles.
   task automatic rises(input int n);
      repeat (n) @(posedge lsclk);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One write strobe; an idle edge follows so strobes never merge.
   task automatic wr(input logic [19:0] a, input logic [7:0] d,
                     input logic b);
      bus_addr <= a;
      bus_wdata <= d;
      bus_bitop <= b;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_bitop <= 1'b0;
      @(posedge clk);
   endtask

   // One read strobe; data stands only in the cycle after the strobe.
   task automatic rd(input logic [19:0] a, input logic [7:0] exp);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 chk("read data", exp, bus_rdata);
      @(posedge clk);
   endtask

   // Reset request and cause flag move together since both are sticky.
   task automatic rst_is(input logic e);
      #1 chk("internal reset", {7'h00, e}, {7'h00, int_rst});
      chk("reset cause", e ? 8'h10 : 8'h00, reset_cause_reg);
      @(posedge clk);
   endtask

   // Main sequence of scenarios.
   initial
   begin
      start(8'h71);
      rd(WWDT_KEY_ADDR, WWDT_READ_ON);
      wr(20'hfffaa, 8'h55, 1'b0);
      rd(20'hfffaa, WWDT_READ_NONE);
      rst_is(1'b0);
      wr(WWDT_KEY_ADDR, 8'h55, 1'b0);
      rst_is(1'b1);
      start(8'h61);
      rd(WWDT_KEY_ADDR, WWDT_READ_OFF);
      rises(100);
      rst_is(1'b0);
      start(8'h71);
      wr(WWDT_KEY_ADDR, WWDT_KEY_VALUE, 1'b1);
      rst_is(1'b1);
      // Overflow lands exactly on the (64 << k)-th slow edge.
      for (int k = 0; k < 4; k++)
      begin
         start({4'h7, k[2:0], 1'b1});
         rises((64 << k) - 1);
         settle(2);
         rst_is(1'b0);
         rises(1);
         settle(3);
         rst_is(1'b1);
      end
      // A first key just before overflow, then a key in the open window.
      start(8'h71);
      rises(62);
      wr(WWDT_KEY_ADDR, WWDT_KEY_VALUE, 1'b0);
      rises(40);
      rst_is(1'b0);
      wr(WWDT_KEY_ADDR, WWDT_KEY_VALUE, 1'b0);
      rises(40);
      rst_is(1'b0);
      // Second key inside or outside the closed part of the window.
      for (int i = 0; i < 6; i++)
      begin
         start(w_opt[i]);
         wr(WWDT_KEY_ADDR, WWDT_KEY_VALUE, 1'b0);
         rises(w_gap[i]);
         wr(WWDT_KEY_ADDR, WWDT_KEY_VALUE, 1'b0);
         rst_is(w_exp[i]);
      end
      // Interval pulse at three quarters; counting carries on after it.
      start(8'hf1);
      rises(46);
      chk("interval pulses", 8'h00, irq_cnt[7:0]);
      rises(14);
      chk("interval pulses", 8'h01, irq_cnt[7:0]);
      rises(4);
      settle(3);
      rst_is(1'b1);
      // Standby with the run option clear halts the count and its exit clears it; with it set the dog still bites.
      start(8'h70);
      rises(50);
      standby <= 1'b1;
      rises(20);
      standby <= 1'b0;
      rises(40);
      rst_is(1'b0);
      start(8'h71);
      standby <= 1'b1;
      rises(66);
      rst_is(1'b1);
      wrap_up();
   end

   // Hang guard, well beyond the roughly 13000 cycles of the sequence.
   initial
   begin
      settle(60000);
      err_total++;
      wrap_up();
   end
endmodule
